// ==== hdl/ssh_host_protocol.sv ====
// opcode layer between host bus bytes and the message pipes
module ssh_host_protocol
    import ssh_pkg::*;
#(
    parameter logic [7:0] VERSION = VERSION_DEFAULT
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic iface_select_pin_a,
    input wire logic iface_select_pin_b,
    input wire logic spi_cs_n,
    input wire logic spi_sck,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic i2c_start,
    input wire logic i2c_stop,
    input wire logic i2c_read,
    input wire logic i2c_rx_valid,
    input wire logic [7:0] i2c_rx_byte,
    input wire logic i2c_tx_take,
    output logic [7:0] i2c_tx_byte,
    output logic [7:0] ctl_byte,
    output logic ctl_valid,
    output logic ctl_end,
    input wire logic [15:0] notice_size,
    input wire logic [7:0] notice_data,
    output logic [15:0] notice_idx,
    output logic notice_pop,
    input wire logic [15:0] sample_size,
    input wire logic [7:0] sample_data,
    output logic [15:0] sample_idx,
    output logic sample_pop,
    output logic pending_data_line,
    output logic pending_data_line_oe,
    output ssh_mode_t iface_mode
);
    typedef struct packed {
        ssh_mode_t mode;
        logic [1:0] settle;
        logic a_s1; logic a_s2; logic b_s1; logic b_s2;
        logic [3:0] cfg;
        logic [7:0] opcode;
        logic rx_first;
        logic cfg_done;
        logic reading;
        logic [2:0] tx_no;
        logic [15:0] idx;
        logic [15:0] sent;
        logic [7:0] tx_byte;
        logic [7:0] ctl_byte;
        logic ctl_valid; logic ctl_end;
        logic notice_pop; logic sample_pop;
        logic ready_out; logic ready_oe;
    } ssh_core_t;

    localparam ssh_core_t CORE_RESET = '{mode: SSH_WAIT, cfg: CFG_RESET,
        rx_first: 1'b1, tx_byte: SPI_FILL, default: '0};

    ssh_core_t st_ff;
    ssh_core_t nxt_st;

    logic is_spi;
    logic is_i2c;
    logic is_act;
    logic s_take;
    logic s_rx_v;
    logic s_start;
    logic s_end;
    logic [7:0] s_rx_b;
    logic f_start;
    logic f_end;
    logic rx_v;
    logic tx_tk;
    logic [7:0] rx_b;

    ssh_spi_slave ssh_spi_slave_inst (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .enable(is_spi),
        .spi_cs_n(spi_cs_n),
        .spi_sck(spi_sck),
        .spi_mosi(spi_mosi),
        .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe),
        .tx_byte(st_ff.tx_byte),
        .tx_take(s_take),
        .rx_byte(s_rx_b),
        .rx_valid(s_rx_v),
        .frame_start(s_start),
        .frame_end(s_end)
    );

    assign is_spi = (st_ff.mode == SSH_SPI);
    assign is_i2c = (st_ff.mode == SSH_I2C);
    assign is_act = is_spi | is_i2c;
    // both buses feed one decoder, so opcodes and payloads match
    assign f_start = is_spi ? s_start : (is_i2c & i2c_start);
    assign f_end = is_spi ? s_end : (is_i2c & i2c_stop);
    assign rx_v = is_spi ? s_rx_v : (is_i2c & i2c_rx_valid);
    assign rx_b = is_spi ? s_rx_b : i2c_rx_byte;
    assign tx_tk = is_spi ? s_take : (is_i2c & i2c_tx_take);

    always_comb begin
        logic [15:0] len;
        logic [15:0] idx_inc;
        logic [7:0] dbyte;
        logic pend;
        logic lvl;
        len = 16'h0001;
        idx_inc = st_ff.idx + 16'h0001;
        dbyte = SPI_FILL;
        pend = 1'b0;
        lvl = 1'b0;
        nxt_st = st_ff;
        nxt_st.ctl_valid = 1'b0;
        nxt_st.ctl_end = 1'b0;
        nxt_st.notice_pop = 1'b0;
        nxt_st.sample_pop = 1'b0;
        nxt_st.a_s1 = iface_select_pin_a;
        nxt_st.a_s2 = st_ff.a_s1;
        nxt_st.b_s1 = iface_select_pin_b;
        nxt_st.b_s2 = st_ff.b_s1;

        // straps read once after release, then the mode is frozen
        if (st_ff.mode == SSH_WAIT) begin
            if (st_ff.settle != STRAP_SETTLE) begin
                nxt_st.settle = st_ff.settle + 2'h1;
            end else begin
                case ({st_ff.a_s2, st_ff.b_s2})
                    2'b11: nxt_st.mode = SSH_I2C;
                    2'b01: nxt_st.mode = SSH_SPI;
                    2'b10: nxt_st.mode = SSH_UHD;
                    default: nxt_st.mode = SSH_UFD;
                endcase
            end
        end

        // wrap length: over-reading restarts the data from the top
        case (st_ff.opcode)
            OP_INFO: len = 16'h0002;
            OP_SIZES: len = 16'h0004;
            OP_NOTICE: len = notice_size;
            OP_SAMPLE: len = sample_size;
            default: len = 16'h0001;
        endcase
        if (len == 16'h0000) begin
            len = 16'h0001;
        end

        case (st_ff.opcode)
            OP_INFO: begin
                dbyte = st_ff.idx[0] ? {4'h0, st_ff.cfg} : VERSION;
            end
            OP_SIZES: begin
                case (st_ff.idx[1:0])
                    2'h0: dbyte = notice_size[7:0];
                    2'h1: dbyte = notice_size[15:8];
                    2'h2: dbyte = sample_size[7:0];
                    default: dbyte = sample_size[15:8];
                endcase
            end
            OP_NOTICE: dbyte = notice_data;
            OP_SAMPLE: dbyte = sample_data;
            default: dbyte = SPI_FILL;
        endcase
        // registered one cycle ahead of the shifter taking it
        if (is_spi && st_ff.tx_no != SPI_LEAD_BYTES) begin
            nxt_st.tx_byte = (st_ff.tx_no == 3'h0) ? SPI_LEAD0 : SPI_FILL;
        end else begin
            nxt_st.tx_byte = dbyte;
        end

        if (f_start) begin
            nxt_st.rx_first = 1'b1;
            nxt_st.tx_no = 3'h0;
            nxt_st.sent = 16'h0000;
            nxt_st.cfg_done = 1'b0;
            nxt_st.reading = is_i2c & i2c_read;
            if (is_i2c && i2c_read) begin
                nxt_st.idx = 16'h0000;
            end
        end

        if (rx_v && !st_ff.reading) begin
            if (st_ff.rx_first) begin
                // first byte of a write always names the operation
                nxt_st.opcode = rx_b;
                nxt_st.rx_first = 1'b0;
                nxt_st.idx = 16'h0000;
            end else begin
                case (st_ff.opcode)
                    OP_CFG: begin
                        // only the first payload byte counts
                        if (!st_ff.cfg_done) begin
                            nxt_st.cfg = rx_b[3:0];
                            nxt_st.cfg_done = 1'b1;
                        end
                    end
                    OP_CTL: begin
                        // reduced message, no preamble or bus id byte
                        nxt_st.ctl_valid = 1'b1;
                        nxt_st.ctl_byte = rx_b;
                    end
                    default: nxt_st.ctl_valid = 1'b0;
                endcase
            end
        end

        if (tx_tk) begin
            if (is_spi && st_ff.tx_no != SPI_LEAD_BYTES) begin
                nxt_st.tx_no = st_ff.tx_no + 3'h1;
            end else begin
                if (st_ff.sent != 16'hFFFF) begin
                    nxt_st.sent = st_ff.sent + 16'h0001;
                end
                nxt_st.idx = (idx_inc >= len) ? 16'h0000 : idx_inc;
            end
        end

        if (f_end) begin
            if (st_ff.opcode == OP_CTL && !st_ff.rx_first &&
                !st_ff.reading) begin
                nxt_st.ctl_end = 1'b1;
            end
            // a pipe read only retires once the whole message went out
            if (is_spi || st_ff.reading) begin
                nxt_st.notice_pop = (st_ff.opcode == OP_NOTICE) &&
                    (notice_size != 16'h0000) && (st_ff.sent >= notice_size);
                nxt_st.sample_pop = (st_ff.opcode == OP_SAMPLE) &&
                    (sample_size != 16'h0000) && (st_ff.sent >= sample_size);
            end
        end

        // uart modes keep the line at its idle level
        pend = is_act && ((st_ff.cfg[CFG_MEV] && sample_size != 16'h0000) ||
            (st_ff.cfg[CFG_NEV] && notice_size != 16'h0000));
        // bit0 taken as the read-back meaning: zero idles low
        lvl = pend ^ st_ff.cfg[CFG_IDLE_LVL];
        if (st_ff.mode == SSH_WAIT) begin
            nxt_st.ready_out = 1'b0;
            nxt_st.ready_oe = 1'b0;
        end else if (st_ff.cfg[CFG_DRV_TYPE]) begin
            nxt_st.ready_out = 1'b0;
            nxt_st.ready_oe = ~lvl;
        end else begin
            nxt_st.ready_out = lvl;
            nxt_st.ready_oe = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= CORE_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // uart modes bypass this layer; the native path is outside
    assign iface_mode = st_ff.mode;
    assign i2c_tx_byte = st_ff.tx_byte;
    assign ctl_byte = st_ff.ctl_byte;
    assign ctl_valid = st_ff.ctl_valid;
    assign ctl_end = st_ff.ctl_end;
    assign notice_idx = st_ff.idx;
    assign sample_idx = st_ff.idx;
    assign notice_pop = st_ff.notice_pop;
    assign sample_pop = st_ff.sample_pop;
    assign pending_data_line = st_ff.ready_out;
    assign pending_data_line_oe = st_ff.ready_oe;

    default clocking cb_core @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_notice_held;
        is_act && st_ff.cfg == CFG_RESET && notice_size != 16'h0000;
    endsequence
    sequence s_cfg_payload;
        rx_v && !st_ff.reading && st_ff.opcode == OP_CFG &&
            !st_ff.rx_first && !st_ff.cfg_done;
    endsequence
    sequence s_ctl_payload;
        rx_v && !st_ff.reading && st_ff.opcode == OP_CTL && !st_ff.rx_first;
    endsequence

    AST_MODE_HOLD: assert property (
        st_ff.mode != SSH_WAIT |=> $stable(st_ff.mode))
        else $error("interface mode changed after startup");
    AST_STRAP_MAP: assert property ($changed(st_ff.mode) |->
        ((st_ff.mode == SSH_I2C) ==
            ($past(st_ff.a_s2) && $past(st_ff.b_s2))) &&
        ((st_ff.mode == SSH_SPI) ==
            (!$past(st_ff.a_s2) && $past(st_ff.b_s2))))
        else $error("strap decode mismatch");
    AST_UART_QUIET: assert property (
        (st_ff.mode == SSH_UHD || st_ff.mode == SSH_UFD) |->
        !ctl_valid && !notice_pop && !sample_pop && !spi_miso_oe)
        else $error("serial layer active in uart mode");
    AST_READY_DEFAULT: assert property (
        s_notice_held ##1 s_notice_held |->
        pending_data_line && pending_data_line_oe)
        else $error("ready line low with notice pending");
    AST_READY_EMPTY: assert property (
        is_act && st_ff.cfg == CFG_RESET && notice_size == 16'h0000 &&
        sample_size == 16'h0000 |=> !pending_data_line)
        else $error("ready line high with pipes empty");
    AST_READY_MASK: assert property (
        is_act && st_ff.cfg[3:1] == 3'b000 |=>
        pending_data_line == $past(st_ff.cfg[CFG_IDLE_LVL]))
        else $error("masked pipes moved the ready line");
    AST_OPEN_DRAIN: assert property (
        is_act && st_ff.cfg[CFG_DRV_TYPE] |=> !pending_data_line)
        else $error("open-drain output drove high");
    AST_CFG_APPLY: assert property (
        s_cfg_payload |=> st_ff.cfg == $past(rx_b[3:0]))
        else $error("config byte not applied");
    AST_INFO_BYTE: assert property (
        st_ff.opcode == OP_INFO && st_ff.idx == 16'h0001 && !is_spi |=>
        st_ff.tx_byte == {4'h0, $past(st_ff.cfg)})
        else $error("info second byte is not the config");
    AST_CTL_FWD: assert property (
        s_ctl_payload |=> ctl_valid && ctl_byte == $past(rx_b))
        else $error("control byte not forwarded");
    AST_POP_FULL: assert property (
        notice_pop |-> $past(st_ff.sent) >= $past(notice_size))
        else $error("notice popped before full read");
endmodule : ssh_host_protocol

// ==== hdl/ssh_pkg.sv ====
// constants and types shared by the host-interface protocol layer
package ssh_pkg;
    localparam logic [7:0] OP_INFO = 8'h01;
    localparam logic [7:0] OP_CFG = 8'h02;
    localparam logic [7:0] OP_CTL = 8'h03;
    localparam logic [7:0] OP_SIZES = 8'h04;
    localparam logic [7:0] OP_NOTICE = 8'h05;
    localparam logic [7:0] OP_SAMPLE = 8'h06;
    localparam int CFG_MEV = 3;
    localparam int CFG_NEV = 2;
    localparam int CFG_DRV_TYPE = 1;
    localparam int CFG_IDLE_LVL = 0;
    localparam logic [3:0] CFG_RESET = 4'hC;
    // arbitrary value
    localparam logic [7:0] VERSION_DEFAULT = 8'h01;
    localparam logic [7:0] SPI_LEAD0 = 8'hFA;
    localparam logic [7:0] SPI_FILL = 8'hFF;
    localparam logic [2:0] SPI_LEAD_BYTES = 3'h4;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    typedef enum logic [4:0] {
        SSH_WAIT = 5'b00001,
        SSH_I2C = 5'b00010,
        SSH_SPI = 5'b00100,
        SSH_UHD = 5'b01000,
        SSH_UFD = 5'b10000
    } ssh_mode_t;
endpackage : ssh_pkg

// ==== hdl/ssh_spi_slave.sv ====
// mode 3 byte shifter, pins sampled on sys_clk
module ssh_spi_slave
    import ssh_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic spi_cs_n,
    input wire logic spi_sck,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic [7:0] tx_byte,
    output logic tx_take,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    output logic frame_start,
    output logic frame_end
);
    typedef struct packed {
        logic cs_s1; logic cs_s2; logic cs_d;
        logic sck_s1; logic sck_s2; logic sck_d;
        logic mosi_s1; logic mosi_s2;
        logic [2:0] cnt;
        logic load_pend;
        logic [7:0] rx_sh;
        logic [7:0] tx_sh;
        logic miso;
        logic rx_valid; logic take; logic start; logic fin;
    } ssh_slv_t;

    localparam ssh_slv_t SLV_RESET = '{cs_s1: 1'b1, cs_s2: 1'b1,
        cs_d: 1'b1, sck_s1: 1'b1, sck_s2: 1'b1, sck_d: 1'b1,
        default: '0};

    ssh_slv_t st_ff;
    ssh_slv_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rx_valid = 1'b0;
        nxt_st.take = 1'b0;
        nxt_st.start = 1'b0;
        nxt_st.fin = 1'b0;
        nxt_st.cs_s1 = spi_cs_n;
        nxt_st.cs_s2 = st_ff.cs_s1;
        nxt_st.cs_d = st_ff.cs_s2;
        nxt_st.sck_s1 = spi_sck;
        nxt_st.sck_s2 = st_ff.sck_s1;
        nxt_st.sck_d = st_ff.sck_s2;
        nxt_st.mosi_s1 = spi_mosi;
        nxt_st.mosi_s2 = st_ff.mosi_s1;
        if (enable) begin
            if (st_ff.cs_d && !st_ff.cs_s2) begin
                nxt_st.start = 1'b1;
                nxt_st.cnt = 3'h0;
                nxt_st.load_pend = 1'b1;
            end else if (!st_ff.cs_d && st_ff.cs_s2) begin
                nxt_st.fin = 1'b1;
            end else if (!st_ff.cs_s2) begin
                if (!st_ff.sck_d && st_ff.sck_s2) begin
                    // capture on the rising edge, msb first
                    nxt_st.rx_sh = {st_ff.rx_sh[6:0], st_ff.mosi_s2};
                    nxt_st.cnt = st_ff.cnt + 3'h1;
                    if (st_ff.cnt == 3'h7) begin
                        nxt_st.rx_valid = 1'b1;
                        nxt_st.load_pend = 1'b1;
                    end
                end else if (st_ff.sck_d && !st_ff.sck_s2) begin
                    // master clocks every bit out of us
                    if (st_ff.load_pend) begin
                        nxt_st.miso = tx_byte[7];
                        nxt_st.tx_sh = {tx_byte[6:0], 1'b0};
                        nxt_st.take = 1'b1;
                        nxt_st.load_pend = 1'b0;
                    end else begin
                        nxt_st.miso = st_ff.tx_sh[7];
                        nxt_st.tx_sh = {st_ff.tx_sh[6:0], 1'b0};
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= SLV_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign spi_miso = st_ff.miso;
    assign spi_miso_oe = enable & ~st_ff.cs_s2;
    assign tx_take = st_ff.take;
    assign rx_byte = st_ff.rx_sh;
    assign rx_valid = st_ff.rx_valid;
    assign frame_start = st_ff.start;
    assign frame_end = st_ff.fin;

    default clocking cb_slv @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    // deselected: no drive and no shifting of the data pin
    AST_SLV_QUIET: assert property (
        st_ff.cs_s2 |-> !spi_miso_oe ##1 $stable(spi_miso))
        else $error("miso driven while deselected");
    AST_SLV_NO_SELF_TX: assert property (
        !(st_ff.sck_d && !st_ff.sck_s2) |=> !tx_take)
        else $error("byte taken without a falling clock edge");
endmodule : ssh_spi_slave

// ==== bench/ssh_pipe_model.sv ====
// message pipes model: one fixed-size message per add pulse
module ssh_pipe_model #(
    parameter logic [15:0] NOTICE_LEN = 16'h0003,
    parameter logic [15:0] SAMPLE_LEN = 16'h0005
)
(
    input logic sys_clk,
    input logic reset_n,
    input logic notice_add,
    input logic sample_add,
    input logic [15:0] notice_idx,
    input logic [15:0] sample_idx,
    input logic notice_pop,
    input logic sample_pop,
    output logic [15:0] notice_size,
    output logic [15:0] sample_size,
    output logic [7:0] notice_data,
    output logic [7:0] sample_data
);
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [3:0] notice_cnt;
        logic [3:0] sample_cnt;
    } ssh_pm_state_t;
    ssh_pm_state_t state_ff;
    ssh_pm_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        if (notice_add) nxt_state.notice_cnt = state_ff.notice_cnt + 4'h1;
        if (sample_add) nxt_state.sample_cnt = state_ff.sample_cnt + 4'h1;
        // pop of an empty pipe is ignored, head stays put
        if (notice_pop && state_ff.notice_cnt != 4'h0)
            nxt_state.notice_cnt = state_ff.notice_cnt - 4'h1;
        if (sample_pop && state_ff.sample_cnt != 4'h0)
            nxt_state.sample_cnt = state_ff.sample_cnt - 4'h1;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) state_ff <= '0;
        else state_ff <= nxt_state;
    end

    assign notice_size = (state_ff.notice_cnt != 4'h0) ? NOTICE_LEN : 16'h0;
    assign sample_size = (state_ff.sample_cnt != 4'h0) ? SAMPLE_LEN : 16'h0;
    // empty pipe shows a scrambled byte, never the last message
    assign notice_data = (state_ff.notice_cnt != 4'h0) ?
        8'h50 + notice_idx[7:0] : ~(8'h50 + notice_idx[7:0]);
    assign sample_data = (state_ff.sample_cnt != 4'h0) ?
        8'h60 + sample_idx[7:0] : ~(8'h60 + sample_idx[7:0]);
endmodule : ssh_pipe_model

// ==== bench/ssh_host_protocol_tb_top.sv ====
// self-checking bench for the host protocol layer
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
    $display("Error %0t: got %h exp %h", $time, a, e); end end
module ssh_host_protocol_tb_top;
    import ssh_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 0, reset_n = 0, pin_a = 1, pin_b = 1;
    logic spi_cs_n = 1, spi_sck = 1, spi_mosi = 1, spi_miso, spi_miso_oe;
    logic i2c_start = 0, i2c_stop = 0, i2c_read = 0, i2c_rx_valid = 0;
    logic i2c_tx_take = 0, ctl_valid, ctl_end, notice_pop, sample_pop;
    logic [7:0] i2c_rx_byte = 8'h00, i2c_tx_byte, ctl_byte;
    logic [7:0] notice_data, sample_data;
    logic [15:0] notice_size, sample_size, notice_idx, sample_idx;
    logic notice_add = 0, sample_add = 0, line, line_oe;
    ssh_mode_t iface_mode;
    int error_cnt = 0, tests_run = 0, cyc = 0, ctl_ends = 0;
    logic [7:0] exp_b [8];
    logic [7:0] ctl_q [$];
    // released data pin floats to the pull-up level
    wire miso_pin = spi_miso_oe ? spi_miso : 1'b1;

    always #4 sys_clk = ~sys_clk;

    ssh_host_protocol ssh_host_protocol_inst (.sys_clk(sys_clk),
        .reset_n(reset_n), .iface_select_pin_a(pin_a),
        .iface_select_pin_b(pin_b), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
        .i2c_start(i2c_start), .i2c_stop(i2c_stop), .i2c_read(i2c_read),
        .i2c_rx_valid(i2c_rx_valid), .i2c_rx_byte(i2c_rx_byte),
        .i2c_tx_take(i2c_tx_take), .i2c_tx_byte(i2c_tx_byte),
        .ctl_byte(ctl_byte), .ctl_valid(ctl_valid), .ctl_end(ctl_end),
        .notice_size(notice_size), .notice_data(notice_data),
        .notice_idx(notice_idx), .notice_pop(notice_pop),
        .sample_size(sample_size), .sample_data(sample_data),
        .sample_idx(sample_idx), .sample_pop(sample_pop),
        .pending_data_line(line), .pending_data_line_oe(line_oe),
        .iface_mode(iface_mode));

    ssh_pipe_model ssh_pipe_model_inst (.sys_clk(sys_clk),
        .reset_n(reset_n), .notice_add(notice_add), .sample_add(sample_add),
        .notice_idx(notice_idx), .sample_idx(sample_idx),
        .notice_pop(notice_pop), .sample_pop(sample_pop),
        .notice_size(notice_size), .sample_size(sample_size),
        .notice_data(notice_data), .sample_data(sample_data));

    always @(posedge sys_clk) begin
        if (ctl_valid === 1'b1) ctl_q.push_back(ctl_byte);
        if (ctl_end === 1'b1) ctl_ends++;
        cyc++;
        // generous ceiling, the whole run needs about 1200 cycles
        if (cyc == 40000) begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("errors %0d, comparisons %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic do_reset();
        reset_n = 0;
        tick(3);
        reset_n = 1;
        tick(8);
    endtask : do_reset

    task automatic add_msg(input logic smp);
        if (smp) sample_add = 1;
        else notice_add = 1;
        tick(1);
        sample_add = 0;
        notice_add = 0;
        tick(3);
    endtask : add_msg

    task automatic frame(input logic rd);
        i2c_read = rd;
        i2c_start = 1;
        tick(1);
        i2c_start = 0;
        tick(3);
    endtask : frame

    task automatic rx(input logic [7:0] b);
        i2c_rx_byte = b;
        i2c_rx_valid = 1;
        tick(1);
        i2c_rx_valid = 0;
        tick(3);
    endtask : rx

    task automatic stop();
        i2c_stop = 1;
        tick(1);
        i2c_stop = 0;
        tick(4);
    endtask : stop

    task automatic wr(input logic [7:0] op, input logic [7:0] b, input bit pl);
        frame(0);
        rx(op);
        if (pl) rx(b);
        stop();
    endtask : wr

    // opcode write frame, then a read frame of n bytes against exp_b
    task automatic rd(input logic [7:0] op, input int n);
        wr(op, 8'h00, 0);
        frame(1);
        for (int i = 0; i < n; i++) begin
            tick(4);
            `CHK(i2c_tx_byte, exp_b[i])
            i2c_tx_take = 1;
            tick(1);
            i2c_tx_take = 0;
        end
        stop();
    endtask : rd

    // mode 3: mosi set on the falling edge, miso taken at the rising one
    task automatic spi_rd(input logic [7:0] op, input int n);
        logic [7:0] tx;
        logic [7:0] got;
        spi_cs_n = 0;
        tick(6);
        for (int i = 0; i < n; i++) begin
            tx = (i == 0) ? op : 8'h00;
            for (int j = 7; j >= 0; j--) begin
                spi_sck = 0;
                spi_mosi = tx[j];
                #62.5;
                spi_sck = 1;
                got = {got[6:0], miso_pin};
                #62.5;
            end
            `CHK(got, exp_b[i])
        end
        tick(2);
        spi_cs_n = 1;
        tick(8);
    endtask : spi_rd

    initial begin
        ssh_mode_t mt [4] = '{SSH_UFD, SSH_SPI, SSH_UHD, SSH_I2C};
        for (int k = 0; k < 4; k++) begin
            {pin_a, pin_b} = k[1:0];
            do_reset();
            `CHK(iface_mode, mt[k])
            {pin_a, pin_b} = ~k[1:0];
            tick(3);
            `CHK(iface_mode, mt[k])
            // the two uart modes: full duplex and half duplex
            if (k % 2 == 0) begin
                add_msg(0);
                spi_cs_n = 0;
                tick(4);
                `CHK(line, 1'b0)
                `CHK(spi_miso_oe, 1'b0)
                spi_cs_n = 1;
            end
        end
        // still in the bus mode picked at reset, straps now flipped
        exp_b = '{VERSION_DEFAULT, 8'h0C, VERSION_DEFAULT, 0, 0, 0, 0, 0};
        rd(OP_INFO, 3);
        `CHK({line, line_oe}, 2'b01)
        add_msg(0);
        `CHK(line, 1'b1)
        exp_b = '{8'h03, 8'h00, 8'h00, 8'h00, 0, 0, 0, 0};
        rd(OP_SIZES, 4);
        frame(0);
        rx(OP_CTL);
        rx(8'hAA);
        rx(8'h55);
        stop();
        `CHK(ctl_q.size(), 2)
        `CHK({ctl_q[0], ctl_q[1]}, 16'hAA55)
        `CHK(ctl_ends, 1)
        wr(OP_CFG, 8'hF8, 1);
        `CHK(line, 1'b0)
        exp_b = '{VERSION_DEFAULT, 8'h08, 0, 0, 0, 0, 0, 0};
        rd(OP_INFO, 2);
        wr(OP_CFG, 8'h0D, 1);
        `CHK(line, 1'b0)
        wr(OP_CFG, 8'h0E, 1);
        `CHK(line_oe, 1'b0)
        exp_b = '{8'h50, 8'h51, 8'h52, 0, 0, 0, 0, 0};
        rd(OP_NOTICE, 3);
        `CHK(notice_size, 16'h0)
        `CHK({line, line_oe}, 2'b01)
        add_msg(1);
        wr(OP_CFG, 8'h04, 1);
        `CHK(line, 1'b0)
        wr(OP_CFG, 8'h01, 1);
        `CHK(line, 1'b1)
        exp_b = '{8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 0, 0, 0};
        rd(OP_SAMPLE, 5);
        `CHK(sample_size, 16'h0)
        {pin_a, pin_b} = 2'b01;
        do_reset();
        exp_b = '{8'hFA, 8'hFF, 8'hFF, 8'hFF, VERSION_DEFAULT, 8'h0C, 0, 0};
        spi_rd(OP_INFO, 6);
        finish_test();
    end
endmodule : ssh_host_protocol_tb_top
